// *** core/sacc_pkg.sv ***
// Shared constants for the converter conversion control block
package sacc_pkg;

  // Result width and bit positions
  localparam int unsigned RES_W = 12;
  localparam logic [3:0] MSB_IDX = 4'hB;
  localparam logic [3:0] LSB_IDX = 4'h0;

  // Trial level loaded at conversion start (half scale)
  localparam logic [RES_W-1:0] HALF_SCALE = 12'h800;

  // Output latch contents before the first conversion
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;

  // Falling input-clock edges per conversion: one skipped, twelve trials
  localparam logic [3:0] FALLS_PER_CONV = 4'hD;

  // Index of the falling edge that decides the top bit
  localparam logic [3:0] MSB_FALL = 4'h2;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_SETTLE,
    SACC_TRIAL
  } sacc_state_e;

endpackage

// *** core/sacc_edge.sv ***
// Input clock edge finder and inverted clock output
`timescale 1ns/1ps
module sacc_edge (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic clock_in,
  output logic      fall,
  output logic      clock_out
);
  import sacc_pkg::*;

  typedef struct packed {
    logic prev;
    logic clk_out;
  } sacc_edge_s;

  sacc_edge_s e_q;
  sacc_edge_s e_d;

  always_comb begin
    e_d = e_q;
    e_d.prev = clock_in;
    e_d.clk_out = ~clock_in;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  // Approximation steps follow input clock falls, i.e. clock_out rises
  assign fall = e_q.prev & ~clock_in;
  assign clock_out = e_q.clk_out;

  // The first edge after reset still shows the reset value, so it is skipped
  property p_clk_inv;
    @(posedge clk_sys) disable iff (!nrst)
      $past(nrst) |-> clock_out == ~$past(clock_in);
  endproperty
  a_clk_inv: assert property (p_clk_inv)
    else $error("clock_out is not the inverted input clock");

  property p_fall_edge;
    @(posedge clk_sys) disable iff (!nrst)
      fall |-> $past(clock_in) && !clock_in;
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("fall pulse without falling input clock");

endmodule

// *** core/sacc_top.sv ***
// Successive-approximation conversion control with three-state result port
`timescale 1ns/1ps
module sacc_top (
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic                         clock_in,
  input  wire logic                         chip_sel_n,
  input  wire logic                         read_n,
  input  wire logic                         comp_greater,
  output logic                              clock_out,
  output logic                              busy_n,
  output logic      [sacc_pkg::RES_W-1:0]   result_bus_o,
  output logic                              result_bus_oe,
  output logic      [sacc_pkg::RES_W-1:0]   dac_trial
);
  import sacc_pkg::*;

  typedef struct packed {
    sacc_state_e             st;
    logic [RES_W-1:0]        approximation_register;
    logic [3:0]              bit_idx;
    logic [RES_W-1:0]        result;
    logic                    busy_n;
    logic                    oe;
    logic                    sel_prev;
  } sacc_s;

  sacc_s s_q;
  sacc_s s_d;

  logic fall;
  logic sel;
  logic start;

  // One-hot mask of the bit under test
  function automatic logic [RES_W-1:0] sacc_bit_mask(input logic [3:0] idx);
    sacc_bit_mask = RES_W'(1) << idx;
  endfunction

  sacc_edge u_edge (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clock_in  (clock_in),
    .fall      (fall),
    .clock_out (clock_out)
  );

  assign sel = ~chip_sel_n & ~read_n;
  // Start on the select edge only; a strobe held through the end does not rerun
  assign start = sel & ~s_q.sel_prev & (s_q.st == SACC_IDLE);

  always_comb begin
    s_d = s_q;
    s_d.sel_prev = sel;
    s_d.oe = sel;
    unique case (s_q.st)
      SACC_IDLE: begin
        if (start) begin
          s_d.approximation_register = HALF_SCALE;
          s_d.bit_idx = MSB_IDX;
          s_d.busy_n = 1'b0;
          s_d.st = SACC_SETTLE;
        end
      end
      SACC_SETTLE: begin
        // First fall is settling time for the external sample-and-hold
        if (fall) begin
          s_d.st = SACC_TRIAL;
        end
      end
      SACC_TRIAL: begin
        if (fall) begin
          // Keep the tested bit only when the input is above the trial level
          if (!comp_greater) begin
            s_d.approximation_register = s_q.approximation_register
              & ~sacc_bit_mask(s_q.bit_idx);
          end
          if (s_q.bit_idx == LSB_IDX) begin
            s_d.result = s_d.approximation_register;
            s_d.busy_n = 1'b1;
            s_d.st = SACC_IDLE;
          end else begin
            s_d.approximation_register = s_d.approximation_register
              | sacc_bit_mask(s_q.bit_idx - 4'h1);
            s_d.bit_idx = s_q.bit_idx - 4'h1;
          end
        end
      end
      default: begin
        s_d.st = SACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q.st <= SACC_IDLE;
      s_q.approximation_register <= HALF_SCALE;
      s_q.bit_idx <= MSB_IDX;
      s_q.result <= RESULT_RST;
      s_q.busy_n <= 1'b1;
      s_q.oe <= 1'b0;
      s_q.sel_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_n = s_q.busy_n;
  assign result_bus_o = s_q.result;
  assign result_bus_oe = s_q.oe;
  assign dac_trial = s_q.approximation_register;

  // Helper: falling edges seen while busy_n is low since the last start
  logic [3:0] falls_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      falls_q <= 4'h0;
    end else if (start) begin
      falls_q <= 4'h0;
    end else if (fall && !s_q.busy_n) begin
      falls_q <= falls_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_start;
    start;
  endsequence

  sequence s_last_trial;
    s_q.st == SACC_TRIAL && fall && s_q.bit_idx == LSB_IDX;
  endsequence

  sequence s_msb_fall;
    s_q.st == SACC_TRIAL && fall && falls_q == MSB_FALL - 4'h1;
  endsequence

  sequence s_settle_fall;
    s_q.st == SACC_SETTLE && fall;
  endsequence

  sequence s_trial_step;
    s_q.st == SACC_TRIAL && fall && s_q.bit_idx != LSB_IDX;
  endsequence

  property p_start_busy;
    s_start |=> !busy_n;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy did not fall after a start");

  property p_preset;
    s_start |=> dac_trial == HALF_SCALE && s_q.st == SACC_SETTLE;
  endproperty
  a_preset: assert property (p_preset)
    else $error("register not at half scale after start");

  // A restart would send a running trial back to the settling state
  property p_no_restart;
    (s_q.st == SACC_TRIAL) && sel |=> s_q.st != SACC_SETTLE;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("select during conversion restarted it");

  property p_bus_drive;
    result_bus_oe == $past(sel);
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("result bus enable does not follow select");

  property p_msb_decide;
    s_msb_fall |=> dac_trial[RES_W-1] == $past(comp_greater)
      && dac_trial[RES_W-2];
  endproperty
  a_msb_decide: assert property (p_msb_decide)
    else $error("top bit not decided on second fall");

  property p_trial_keep;
    s_q.st == SACC_TRIAL && fall |=>
      dac_trial[$past(s_q.bit_idx)] == $past(comp_greater);
  endproperty
  a_trial_keep: assert property (p_trial_keep)
    else $error("tested bit does not match comparator");

  property p_next_trial;
    s_q.st == SACC_TRIAL && fall && s_q.bit_idx != LSB_IDX |=>
      dac_trial[$past(s_q.bit_idx) - 4'h1];
  endproperty
  a_next_trial: assert property (p_next_trial)
    else $error("next trial bit not set");

  property p_finish;
    s_last_trial |=> busy_n && result_bus_o == dac_trial
      && falls_q == FALLS_PER_CONV;
  endproperty
  a_finish: assert property (p_finish)
    else $error("conversion end did not raise busy with result");

  property p_busy_span;
    $rose(busy_n) |-> falls_q == FALLS_PER_CONV;
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy rose before all trials were done");

  property p_sar_on_fall;
    !$stable(dac_trial) |-> $past(fall) || $past(start);
  endproperty
  a_sar_on_fall: assert property (p_sar_on_fall)
    else $error("register changed without a clock fall");

  property p_hold_result;
    !busy_n && $past(!busy_n) |-> $stable(result_bus_o);
  endproperty
  a_hold_result: assert property (p_hold_result)
    else $error("result changed during conversion");

  property p_idle_busy;
    s_q.st == SACC_IDLE |-> busy_n;
  endproperty
  a_idle_busy: assert property (p_idle_busy)
    else $error("busy low while idle");

  property p_settle_hold;
    s_q.st == SACC_SETTLE && !fall |=> s_q.st == SACC_SETTLE;
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("settling state left without a clock fall");

  property p_settle_exit;
    s_settle_fall |=> s_q.st == SACC_TRIAL && dac_trial == HALF_SCALE;
  endproperty
  a_settle_exit: assert property (p_settle_exit)
    else $error("first fall changed the register");

  property p_run_busy;
    s_q.st != SACC_IDLE |-> !busy_n;
  endproperty
  a_run_busy: assert property (p_run_busy)
    else $error("busy high while converting");

  property p_result_change;
    !$stable(result_bus_o) |-> $rose(busy_n);
  endproperty
  a_result_change: assert property (p_result_change)
    else $error("result changed away from conversion end");

  property p_idle_stay;
    s_q.st == SACC_IDLE && !start |=> s_q.st == SACC_IDLE;
  endproperty
  a_idle_stay: assert property (p_idle_stay)
    else $error("conversion began without a select edge");

  property p_low_bits;
    s_q.st == SACC_TRIAL |->
      (dac_trial & (sacc_bit_mask(s_q.bit_idx) - 12'h001)) == 12'h000;
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("bits below the tested bit are not clear");

  property p_idx_range;
    s_q.bit_idx <= MSB_IDX;
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("bit index out of range");

  property p_falls_bound;
    falls_q <= FALLS_PER_CONV;
  endproperty
  a_falls_bound: assert property (p_falls_bound)
    else $error("too many falls in one conversion");

  property p_idx_step;
    s_trial_step |=> s_q.bit_idx == $past(s_q.bit_idx) - 4'h1;
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("bit index did not step down");

  property p_end_idle;
    s_last_trial |=> s_q.st == SACC_IDLE;
  endproperty
  a_end_idle: assert property (p_end_idle)
    else $error("sequencer not idle after last trial");

  property p_busy_fall;
    $fell(busy_n) |-> $past(start);
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy fell without a start");

  property p_settle_count;
    s_q.st == SACC_SETTLE |-> falls_q == 4'h0;
  endproperty
  a_settle_count: assert property (p_settle_count)
    else $error("fall counted before settling ended");

  // In the trial state, tested index and counted falls add up to the trial count
  property p_trial_count;
    s_q.st == SACC_TRIAL |-> falls_q + s_q.bit_idx == FALLS_PER_CONV - 4'h1;
  endproperty
  a_trial_count: assert property (p_trial_count)
    else $error("trial index out of step with clock falls");

  property p_end_rise;
    $rose(busy_n) |-> s_q.st == SACC_IDLE;
  endproperty
  a_end_rise: assert property (p_end_rise)
    else $error("busy rose while still converting");

  property p_settle_preset;
    s_q.st == SACC_SETTLE |-> dac_trial == HALF_SCALE;
  endproperty
  a_settle_preset: assert property (p_settle_preset)
    else $error("register not at half scale while settling");

  property p_result_hold;
    s_q.st != SACC_TRIAL |=> $stable(result_bus_o);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside a trial");

endmodule

// *** testbench/sacc_analog_model.sv ***
// Comparator and external converter clock model for the bench
`timescale 1ns/1ps
module sacc_analog_model (
  input  wire logic [sacc_pkg::RES_W-1:0] dac_trial,
  input  wire logic [sacc_pkg::RES_W-1:0] vin,
  input  wire logic                       clk_sys,
  output logic                            clock_in,
  output logic                            comp_greater
);
  int cnt = 0;
  initial clock_in = 1'b0;
  // Free-running source; four system cycles a phase keeps it slow enough to sample
  always @(posedge clk_sys) begin
    cnt <= (cnt == 3) ? 0 : cnt + 1;
    if (cnt == 3) clock_in <= #2 ~clock_in;
  end
  // Ideal comparator, strict so an equal trial level is dropped
  assign comp_greater = (vin > dac_trial);
endmodule

// *** testbench/test_sar_adc_conversion_control.sv ***
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module test_sar_adc_conversion_control;
  import sacc_pkg::*;
  logic             clk_sys = 0, nrst = 0, chip_sel_n = 1, read_n = 1;
  logic [RES_W-1:0] vin = '0, last_q = RESULT_RST, exp_v, result_bus_o, dac_trial;
  logic             clock_in, comp_greater, clock_out, busy_n, result_bus_oe, ci_q;
  int               errors = 0, n_compared = 0, cyc = 0, lowc = 0;
  always #12.5 clk_sys = ~clk_sys;
  sacc_analog_model model_u (.dac_trial(dac_trial), .vin(vin), .clk_sys(clk_sys),
    .clock_in(clock_in), .comp_greater(comp_greater));
  sacc_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .clock_in(clock_in),
    .chip_sel_n(chip_sel_n), .read_n(read_n), .comp_greater(comp_greater),
    .clock_out(clock_out), .busy_n(busy_n), .result_bus_o(result_bus_o),
    .result_bus_oe(result_bus_oe), .dac_trial(dac_trial));
  task automatic finish_test;
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Integer model of the bit-by-bit search
  function automatic logic [RES_W-1:0] sar_model(int v);
    int r = 0;
    for (int b = RES_W - 1; b >= 0; b--) if (v > (r | (1 << b))) r = r | (1 << b);
    return r[RES_W-1:0];
  endfunction
  always @(posedge clk_sys) begin
    cyc++;
    ci_q <= clock_in;
    if (busy_n === 1'b0) lowc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  always @(negedge clk_sys) if (cyc > 16) `CHK("clock_out", ~ci_q, clock_out)
  task automatic convert(bit rom);
    int w;
    @(posedge clk_sys);
    #2 vin = $urandom_range(0, 4095);
    exp_v = sar_model(vin);
    lowc = 0;
    {chip_sel_n, read_n} = 2'b00;
    @(posedge clk_sys);
    #2 `CHK("busy_start", 1'b0, busy_n)
    `CHK("preset", HALF_SCALE, dac_trial)
    `CHK("oe_on", 1'b1, result_bus_oe)
    `CHK("old_data", last_q, result_bus_o)
    if (rom) begin
      {chip_sel_n, read_n} = 2'b11;
      repeat (2) @(posedge clk_sys);
      #2 `CHK("oe_off", 1'b0, result_bus_oe)
      // A second strobe mid-conversion must not disturb the count or result
      repeat (20) @(posedge clk_sys);
      #2 {chip_sel_n, read_n} = 2'b00;
      @(posedge clk_sys);
      #2 {chip_sel_n, read_n} = 2'b11;
    end
    for (w = 0; w < 300 && busy_n !== 1'b1; w++) begin
      @(posedge clk_sys);
      #2;
    end
    `CHK("result", exp_v, result_bus_o)
    `CHK("conv_len", 1'b1, (lowc >= 96 && lowc <= 106))
    repeat (3) @(posedge clk_sys);
    #2 `CHK("no_restart", 1'b1, busy_n)
    `CHK("oe_held", ~rom, result_bus_oe)
    {chip_sel_n, read_n} = 2'b11;
    last_q = exp_v;
    repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    void'($urandom(12891));
    repeat (12) @(posedge clk_sys);
    #2 nrst = 1;
    @(posedge clk_sys);
    #2 `CHK("busy_reset", 1'b1, busy_n)
    `CHK("data_reset", RESULT_RST, result_bus_o)
    for (int i = 0; i < 12; i++) convert(i[0]);
    finish_test();
  end
endmodule
